// [verilog/sdp_ram_port.sv]
/*
  One synchronous port with its own array view: registered inputs, burst
  counter, flow-through or pipelined read path, async output enable.
  Assumes the master on the interface keeps setup, clock period and
  chip-select conventions; a second port may share mem via the testbench.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdp_params.svh"
module sdp_ram_port #(
  parameter int ADDR_W = `SDP_ADDR_W,
  parameter int DATA_W = `SDP_DATA_W,
  parameter int DEPTH  = 1 << `SDP_ADDR_W
) (
  input  wire logic clock_i,   // Port clock.
  input  wire logic rst_i,     // Synchronous reset, active high.
  sdp_if.ram        bus,       // Pins facing the master.
  output logic [DATA_W-1:0] rd_data_o,  // Output register, reloaded every cycle.
  output logic              rd_valid_o  // Read data valid this cycle; oe_n does not gate it.
);
  import sdp_pkg::*;

  // Geometry that the logic cannot serve is refused at elaboration.
  if (ADDR_W != `SDP_ADDR_W) begin : g_bad_addr_w
    $error("sdp_ram_port: address width must match the pins");
  end
  if (DATA_W != `SDP_DATA_W) begin : g_bad_data_w
    $error("sdp_ram_port: data width must match the pins");
  end
  if (DEPTH > (1 << ADDR_W)) begin : g_bad_depth_hi
    $error("sdp_ram_port: depth exceeds the address range");
  end
  if (DEPTH < 2) begin : g_bad_depth_lo
    $error("sdp_ram_port: depth must be two words or more");
  end

  logic [DATA_W-1:0] mem [DEPTH];

  // Registered pin inputs, burst counter, later stages and the nets feeding them.
  logic [ADDR_W-1:0] cnt_q;
  logic [ADDR_W-1:0] cnt_d;
  logic [ADDR_W-1:0] addr_q;
  logic              sel_q;
  logic              rw_q;
  logic [DATA_W-1:0] wdata_q;
  logic              read_q;
  logic              read_pipe_q;
  logic              pipe_q;
  logic [DATA_W-1:0] flow_q;
  logic [DATA_W-1:0] pipe_data_q;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic              drive_q;
  logic              drive_d;
  logic              wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] wr_data_q;
  logic              fwd_hit;
  logic [ADDR_W-1:0] int_addr;
  logic              sel;

  function automatic logic [ADDR_W-1:0] sdp_wrap_inc(
    input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(DEPTH - 1)) begin
      return '0;
    end
    return a + ADDR_W'(1);
  endfunction

  assign sel = !bus.select_low_active && bus.select_high_active;
  // Internal address is the pins when strobed, else the counter.
  assign int_addr = !bus.address_strobe_n ? bus.addr : cnt_q;

  // Burst counter: clear beats load beats increment.
  always_comb begin
    cnt_d = cnt_q;
    if (!bus.count_clear_n) begin
      cnt_d = `SDP_CNT_RESET;
    end else if (!bus.address_strobe_n) begin
      cnt_d = bus.addr;
    end else if (!bus.count_advance_n) begin
      cnt_d = sdp_wrap_inc(cnt_q);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_q <= `SDP_CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Chip selects and direction are registered on every edge.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sel_q <= 1'b0;
      rw_q  <= 1'b1;
    end else begin
      sel_q <= sel;
      rw_q  <= bus.rw;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      addr_q <= '0;
    end else if (!bus.count_clear_n) begin
      addr_q <= '0;
    end else begin
      addr_q <= int_addr;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wdata_q <= '0;
      pipe_q  <= 1'b0;
    end else begin
      wdata_q <= bus.dq_from_master;
      pipe_q  <= bus.flow_pipe_select;
    end
  end

  // Writes land two cycles after capture; the self-timed pulse is modelled
  // as a pending write so the other port sees it after the delay window.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      wr_pend_q <= sel_q && !rw_q;
      wr_addr_q <= addr_q;
      wr_data_q <= wdata_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (wr_pend_q) begin
      mem[wr_addr_q] <= wr_data_q;
    end
  end

  // Read timing, counted from the edge that registers the pins: the next
  // edge fetches the word into the flow stage, the one after loads it
  // into the output register in flow-through mode, and pipelined mode
  // adds one edge more. The flow stage stands in for the array access
  // time, which would otherwise vanish inside one slow clock period.
  // A write still pending at the read address is forwarded.
  assign fwd_hit = wr_pend_q && (wr_addr_q == addr_q);

  // Read path: flow stage holds array data for the captured address.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      read_q      <= 1'b0;
      read_pipe_q <= 1'b0;
      flow_q      <= '0;
      pipe_data_q <= '0;
    end else begin
      read_q      <= sel_q && rw_q;
      read_pipe_q <= read_q;
      flow_q      <= fwd_hit ? wr_data_q : mem[addr_q];
      pipe_data_q <= flow_q;
    end
  end

  // A deselect sampled at an edge floats the pins after that same edge;
  // the read qualifier comes from the stage of the selected mode.
  always_comb begin
    drive_d   = read_q && sel;
    rd_data_d = flow_q;
    if (pipe_q) begin
      drive_d   = read_pipe_q && sel;
      rd_data_d = pipe_data_q;
    end else begin
      rd_data_d = flow_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      drive_q   <= 1'b0;
      rd_data_q <= '0;
    end else begin
      drive_q   <= drive_d;
      rd_data_q <= rd_data_d;
    end
  end

  // Output enable gates the pins without waiting for a clock.
  assign bus.dq_ram_oe   = drive_q && !bus.oe_n;
  assign bus.dq_from_ram = rd_data_q;
  assign rd_data_o       = rd_data_q;
  assign rd_valid_o      = drive_q;
endmodule
`default_nettype wire

// [verilog/sdp_params.svh]
/*
  Constants for the synchronous dual-port RAM port and its bus master.
  Assumes inclusion by bare name from the package and both end files.
*/
`ifndef SDP_PARAMS_SVH
`define SDP_PARAMS_SVH

`define SDP_ADDR_W        17
`define SDP_DATA_W        9
`define SDP_CLK_PERIOD_NS 100
`define SDP_CYC_PIPE_NS   12
`define SDP_CYC_FLOW_NS   22
`define SDP_CCW_NS        10
`define SDP_WRD_NS        35
`define SDP_WRD_CYC ((`SDP_WRD_NS + `SDP_CLK_PERIOD_NS - 1) / `SDP_CLK_PERIOD_NS)
`define SDP_CNT_RESET     17'h00000

`endif

// [verilog/sdp_pkg.sv]
/*
  Types shared by the RAM port, its bus master and the joining interface.
  Assumes sdp_params.svh is on the include path.
*/
`include "sdp_params.svh"
package sdp_pkg;
  typedef logic [`SDP_ADDR_W-1:0] sdp_addr_t;
  typedef logic [`SDP_DATA_W-1:0] sdp_data_t;
  typedef enum logic [2:0] {
    SDP_M_IDLE  = 3'b001,
    SDP_M_CMD   = 3'b010,
    SDP_M_WAIT  = 3'b100
  } sdp_mst_state_t;
endpackage

// [verilog/sdp_if.sv]
/*
  Pin bundle of one RAM port, between the RAM port logic and its master.
  Assumes the testbench supplies the port clock and resolves data pins.
*/
`timescale 1ns/1ps
`default_nettype none
interface sdp_if;
  import sdp_pkg::*;
  logic      select_low_active;
  logic      select_high_active;
  logic      address_strobe_n;
  logic      count_advance_n;
  logic      count_clear_n;
  logic      flow_pipe_select;
  logic      rw;
  logic      oe_n;
  sdp_addr_t addr;
  sdp_data_t dq_from_master;
  logic      dq_master_oe;
  sdp_data_t dq_from_ram;
  logic      dq_ram_oe;

  modport ram (
    input  select_low_active, select_high_active, address_strobe_n,
    input  count_advance_n, count_clear_n, flow_pipe_select, rw, oe_n,
    input  addr, dq_from_master, dq_master_oe,
    output dq_from_ram, dq_ram_oe
  );
  modport master (
    output select_low_active, select_high_active, address_strobe_n,
    output count_advance_n, count_clear_n, flow_pipe_select, rw, oe_n,
    output addr, dq_from_master, dq_master_oe,
    input  dq_from_ram, dq_ram_oe
  );
endinterface
`default_nettype wire

// [verilog/sdp_master.sv]
/*
  Bus master end: issues one read or write on request, holds chip
  selects, strobes addresses and waits for the read latency.
  Assumes the RAM port end sits on the same interface and clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdp_params.svh"
module sdp_master (
  input  wire logic              clock_i,   // Port clock.
  input  wire logic              rst_i,     // Synchronous reset, high.
  sdp_if.master                  bus,       // Pins facing the RAM.
  input  wire logic              pipe_i,    // 1 pipelined, 0 flow.
  input  wire logic              req_i,     // Request pulse.
  input  wire logic              write_i,   // 1 write, 0 read.
  input  wire sdp_pkg::sdp_addr_t addr_i,   // Access address.
  input  wire sdp_pkg::sdp_data_t wdata_i,  // Write data.
  output logic                   busy_o,    // Access in progress.
  output logic                   done_o,    // Access done pulse.
  output sdp_pkg::sdp_data_t     rdata_o    // Read data.
);
  import sdp_pkg::*;

  sdp_mst_state_t state_q;
  logic [1:0]     wait_q;
  logic           wr_q;
  sdp_addr_t      addr_q;
  sdp_data_t      wdata_q;
  logic           pipe_q;
  logic           busy_q;
  logic           done_q;
  sdp_data_t      rdata_q;
  logic           sel_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= SDP_M_IDLE;
      wait_q  <= '0;
      wr_q    <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
      pipe_q  <= 1'b0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= '0;
      sel_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        SDP_M_IDLE: begin
          sel_q <= 1'b0;
          if (req_i) begin
            wr_q    <= write_i;
            addr_q  <= addr_i;
            wdata_q <= wdata_i;
            pipe_q  <= pipe_i;
            busy_q  <= 1'b1;
            sel_q   <= 1'b1;
            state_q <= SDP_M_CMD;
          end
        end
        SDP_M_CMD: begin
          // Output is seen two edges later flow, three pipelined.
          wait_q  <= pipe_q ? 2'd3 : 2'd2;
          state_q <= SDP_M_WAIT;
        end
        SDP_M_WAIT: begin
          if (wait_q == 2'd0) begin
            if (!wr_q) begin
              rdata_q <= bus.dq_from_ram;
            end
            sel_q   <= 1'b0;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
            state_q <= SDP_M_IDLE;
          end else begin
            wait_q <= wait_q - 2'd1;
          end
        end
        default: state_q <= SDP_M_IDLE;
      endcase
    end
  end

  assign bus.select_low_active  = !sel_q;
  assign bus.select_high_active = sel_q;
  // Strobe only in the command cycle; the loaded counter then holds it.
  assign bus.address_strobe_n   = !(state_q == SDP_M_CMD);
  assign bus.count_advance_n    = 1'b1;
  assign bus.count_clear_n      = 1'b1;
  assign bus.flow_pipe_select   = pipe_q;
  // Write only in the command cycle; selected read cycles follow in the wait,
  // so no no-operation cycle sits between a write and a read at one address.
  assign bus.rw             = !(wr_q && state_q == SDP_M_CMD);
  assign bus.oe_n           = wr_q;
  assign bus.addr           = addr_q;
  assign bus.dq_from_master = wdata_q;
  assign bus.dq_master_oe   = wr_q && state_q == SDP_M_CMD;
  assign busy_o  = busy_q;
  assign done_o  = done_q;
  assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// [tb/sdp_props.sv]
/*
  Checker on the pin bundle between the RAM port and its master.
  Assumes the bench instantiates it beside the joining interface.
*/
`timescale 1ns/1ps
`default_nettype none
module sdp_props (
  input wire logic clock_i,            // Port clock.
  input wire logic rst_i,              // Synchronous reset.
  input wire logic select_low_active,  // Low selects.
  input wire logic select_high_active, // High selects.
  input wire logic flow_pipe_select,   // 1 pipelined.
  input wire logic rw,                 // 0 write.
  input wire logic oe_n,               // Async output enable.
  input wire logic dq_master_oe,       // Master drives data.
  input wire logic dq_ram_oe           // RAM drives data.
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire logic sel = !select_low_active && select_high_active;

  property p_oe_async; oe_n |-> !dq_ram_oe; endproperty
  a_oe_async: assert property (p_oe_async)
    else $error("ram drives while output enable is high");
  property p_desel; !sel |=> !dq_ram_oe; endproperty
  a_desel: assert property (p_desel)
    else $error("ram drives after deselect edge");
  property p_reset; $fell(rst_i) |-> !dq_ram_oe; endproperty
  a_reset: assert property (p_reset)
    else $error("ram drives right after reset");
  property p_flow; sel && rw && !flow_pipe_select && !oe_n
    |-> ##[1:3] dq_ram_oe; endproperty
  a_flow: assert property (p_flow)
    else $error("flow read not driven in time");
  property p_pipe_late;
    sel && !$past(sel) && rw && flow_pipe_select && !oe_n
      |-> ##3 !dq_ram_oe ##1 dq_ram_oe;
  endproperty
  a_pipe_late: assert property (p_pipe_late)
    else $error("pipelined read driven too early");
  property p_no_fight; dq_ram_oe |-> !dq_master_oe; endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive data");
  property p_master_wr; dq_master_oe |-> !rw && sel; endproperty
  a_master_wr: assert property (p_master_wr)
    else $error("master drives data outside a write");
  property p_read_ctl; dq_ram_oe |-> $past(rw); endproperty
  a_read_ctl: assert property (p_read_ctl)
    else $error("drive not decided by previous read");

  c_write: cover property (sel && !rw);
  c_flow: cover property (dq_ram_oe && !flow_pipe_select);
  c_pipe: cover property (dq_ram_oe && flow_pipe_select);
endmodule
`default_nettype wire

// [tb/sdp_ram_port_tb.sv]
/*
  Testbench joining the RAM port and its master on one interface.
  Assumes the design package and the parameter header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module sdp_ram_port_tb;
  import sdp_pkg::*;
  logic      clock_i, rst_i, pipe_i, req_i, write_i;
  logic      busy_o, done_o, rd_valid_o;
  sdp_addr_t addr_i;
  sdp_data_t wdata_i, rdata_o, rd_data_o;
  int        fails, checked, lat, lat_flow;

  sdp_if i_bus ();
  sdp_ram_port i_sdp_ram_port (.clock_i(clock_i), .rst_i(rst_i),
    .bus(i_bus), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
  sdp_master i_sdp_master (.clock_i(clock_i), .rst_i(rst_i), .bus(i_bus),
    .pipe_i(pipe_i), .req_i(req_i), .write_i(write_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o));
  sdp_props i_sdp_props (.clock_i(clock_i), .rst_i(rst_i),
    .select_low_active(i_bus.select_low_active),
    .select_high_active(i_bus.select_high_active),
    .flow_pipe_select(i_bus.flow_pipe_select), .rw(i_bus.rw),
    .oe_n(i_bus.oe_n), .dq_master_oe(i_bus.dq_master_oe),
    .dq_ram_oe(i_bus.dq_ram_oe));

  task automatic end_sim();
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One access; returns at the cycle after done so the next may follow.
  task automatic access(input logic wr, input sdp_addr_t a,
                        input sdp_data_t d, input sdp_data_t exp);
    req_i = 1'b1;
    write_i = wr;
    addr_i = a;
    wdata_i = d;
    @(posedge clock_i);
    #1 req_i = 1'b0;
    check(busy_o, 1'b1);
    lat = 1;
    while (done_o !== 1'b1 && lat < 30) begin
      @(posedge clock_i);
      #1 lat++;
    end
    check(lat < 30, 1'b1);
    if (!wr) begin
      check(rdata_o, exp);
      check(rd_data_o, exp);
      check(rd_valid_o, 1'b1);
    end
    check(busy_o, 1'b0);
    @(posedge clock_i);
    #1;
    check(done_o, 1'b0);
  endtask

  task automatic t_flow();
    pipe_i = 1'b0;
    access(1'b1, 17'h00000, 9'h1a5, 9'h000);
    access(1'b1, 17'h1ffff, 9'h05a, 9'h000);
    access(1'b0, 17'h00000, 9'h000, 9'h1a5);
    lat_flow = lat;
    access(1'b0, 17'h1ffff, 9'h000, 9'h05a);
  endtask

  task automatic t_pipe();
    pipe_i = 1'b1;
    access(1'b0, 17'h00000, 9'h000, 9'h1a5);
    check(lat, lat_flow + 1);
    access(1'b1, 17'h1ffff, 9'h133, 9'h000);
    access(1'b0, 17'h1ffff, 9'h000, 9'h133);
  endtask

  task automatic t_scatter();
    sdp_addr_t a [4] = '{17'h00123, 17'h10000, 17'h00007, 17'h0fffe};
    sdp_data_t d [4] = '{9'h001, 9'h1fe, 9'h0c3, 9'h13c};
    pipe_i = 1'b0;
    foreach (a[i]) access(1'b1, a[i], d[i], 9'h000);
    for (int i = 3; i >= 0; i--) begin
      pipe_i = i[0];
      access(1'b0, a[i], 9'h000, d[i]);
    end
  endtask

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  initial begin
    #(2000 * 100);
    fails++;
    end_sim();
  end

  initial begin
    fails = 0;
    checked = 0;
    rst_i = 1'b1;
    pipe_i = 1'b0;
    req_i = 1'b0;
    write_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    repeat (5) @(posedge clock_i);
    #1 rst_i = 1'b0;
    t_flow();
    t_pipe();
    t_scatter();
    end_sim();
  end
endmodule
`default_nettype wire
